// file: rtl/inhibit_regs.vh
// register map, field layout and limits of the inhibit band classifier
`ifndef INHIBIT_REGS_VH
`define INHIBIT_REGS_VH

// ==========================================================
// percentage scale
`define PCT_W 7
`define PCT_MAX 7'h64
`define PCT_ZERO 7'h00
`define RES_W 8
`define RES_FULL 8'h64

// ==========================================================
// band codes
`define BAND_W 2
`define BAND_0 2'h0
`define BAND_1 2'h1
`define BAND_2 2'h2
`define BAND_3 2'h3

// ==========================================================
// sizes
`define N_INPUTS 4
`define N_DRIVE 5
`define N_ACT 4
`define ASSIGN_W 3
`define ASSIGN_OFF 3'h0
`define ASSIGN_FIRST 3'h2
`define ASSIGN_LAST 3'h5

// ==========================================================
// word indices (byte address = index * 4)
`define IDX_W 6
`define IDX_THR_BASE 6'h04
`define IDX_DASG_BASE 6'h08
`define IDX_DSPD_BASE 6'h10
`define IDX_ACT_BASE 6'h18
`define IDX_LEVEL 6'h20
`define IDX_BAND 6'h21
`define IDX_DRIVE 6'h22
`define IDX_BLOCK 6'h23

// ==========================================================
// field positions
`define F_THR_LOW 0
`define F_THR_MID 8
`define F_THR_UP 16
`define F_ACT_UP_ASG 0
`define F_ACT_UP_FLG 4
`define F_ACT_DN_ASG 8
`define F_ACT_DN_FLG 12
`define F_DRV_INH 8
`define F_BLK_DN 8

// ==========================================================
// reset values
`define RST_THR 32'h00000000
`define RST_DASG 32'h00000000
`define RST_DSPD 32'h64646464
`define RST_ACT 32'h00000000

// ==========================================================
// axi answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// file: rtl/level_sampler.v
// pin-side resistance code synchroniser and percentage conversion
`timescale 1ns/1ps
`include "inhibit_regs.vh"

module level_sampler (
  input wire aclk,
  input wire aresetn,
  input wire [`RES_W-1:0] res_code, // resistance to ground in 100 ohm units
  output reg [`PCT_W-1:0] level_q // input level in percent
);

  // ==========================================================
  // three stage synchroniser
  reg [`RES_W-1:0] s1_q; // first stage, read only by s2
  reg [`RES_W-1:0] s2_q;
  reg [`RES_W-1:0] s3_q;

  always @(posedge aclk) begin
    if (!aresetn) begin
      s1_q <= {`RES_W{1'b0}};
      s2_q <= {`RES_W{1'b0}};
      s3_q <= {`RES_W{1'b0}};
      level_q <= `PCT_ZERO;
    end else begin
      s1_q <= res_code;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // a change counts once stages two and three agree
      if (s2_q == s3_q) begin
        if (s3_q >= `RES_FULL)
          level_q <= `PCT_MAX; // 10 kohm or more saturates [RULE4]
        else
          level_q <= s3_q[`PCT_W-1:0]; // short reads 0, 1 step per 100 ohm [RULE3] [RULE5]
      end
    end
  end

endmodule // level_sampler

// file: rtl/band_sorter.v
// sorts one input level into one of four bands
`timescale 1ns/1ps
`include "inhibit_regs.vh"

module band_sorter (
  input wire aclk,
  input wire aresetn,
  input wire [`PCT_W-1:0] level, // sampled level
  input wire [`PCT_W-1:0] thr_low, // lower threshold
  input wire [`PCT_W-1:0] thr_mid, // middle threshold
  input wire [`PCT_W-1:0] thr_up, // upper threshold
  output reg [`BAND_W-1:0] band_q // selected band
);

  // ==========================================================
  // comparison, equal goes to the higher band; upper checked first
  // so that out-of-order thresholds still give exactly one band
  always @(posedge aclk) begin
    if (!aresetn) begin
      band_q <= `BAND_0;
    end else if (level >= thr_up) begin
      band_q <= `BAND_3; // [RULE9] [RULE16]
    end else if (level >= thr_mid) begin
      band_q <= `BAND_2; // [RULE9]
    end else if (level >= thr_low) begin
      band_q <= `BAND_1; // [RULE9]
    end else begin
      band_q <= `BAND_0; // [RULE6]
    end
  end

endmodule // band_sorter

// file: rtl/inhibit_band_classifier.v
// inhibit input band classifier with drive and actuator gating
// ==========================================================
// Notes on behaviour
// RULE1 - inputs 2,3 main unit; 4,5 seating unit
// RULE2 - each input yields four distinct states
// RULE3 - input shorted to ground reads 0%
// RULE4 - 10 kohm or more saturates at 100%
// RULE5 - 100 equal one-percent steps between ends
// RULE6 - each level falls in exactly one band
// RULE7 - three programmable thresholds per input
// RULE8 - thresholds accept 0..100% in 1% steps
// RULE9 - lower, middle, upper separate bands 0..3
// RULE10 - inputs act only through assigned software inhibits
// RULE11 - drive inhibit picks per-band speed limit
// RULE12 - 0% limit forces full inhibit, brakes held
// RULE13 - actuator up/down assignments with band flags
// RULE14 - one input may drive both directions
// RULE15 - flagged band blocks that direction
// RULE16 - equal level goes higher; reevaluate each sample
// RULE17 - several drive inhibits: lowest limit wins
//
// Chosen here: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "inhibit_regs.vh"

module inhibit_band_classifier (
  input wire aclk,
  input wire aresetn,
  // inhibit inputs, resistance code in 100 ohm units
  input wire [`RES_W-1:0] pm_inhibit2_res,
  input wire [`RES_W-1:0] pm_inhibit3_res,
  input wire [`RES_W-1:0] seating_lighting_unit_inhibit4_res,
  input wire [`RES_W-1:0] seating_lighting_unit_inhibit5_res,
  // drive and actuator gating
  output reg [`PCT_W-1:0] drive_speed_limit_q,
  output reg drive_inhibit_q,
  output reg [`N_ACT-1:0] act_up_block_q,
  output reg [`N_ACT-1:0] act_down_block_q,
  // axi4-lite slave
  input wire [7:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);

  // ==========================================================
  // storage
  reg [31:0] thr_q [0:`N_INPUTS-1]; // thresholds per input
  reg [31:0] dasg_q [0:`N_DRIVE-1]; // drive inhibit assignment
  reg [31:0] dspd_q [0:`N_DRIVE-1]; // per-band speed limits
  reg [31:0] act_q [0:`N_ACT-1]; // actuator up/down assignment and flags

  // ==========================================================
  // level sampling and band sorting, one pair per input
  wire [`RES_W*`N_INPUTS-1:0] res_bus; // packed input codes
  wire [`PCT_W*`N_INPUTS-1:0] level_bus; // packed levels
  wire [`BAND_W*`N_INPUTS-1:0] band_bus; // packed bands

  // input 2 at slot 0 up to input 5 at slot 3 [RULE1]
  assign res_bus = {seating_lighting_unit_inhibit5_res, seating_lighting_unit_inhibit4_res,
                    pm_inhibit3_res, pm_inhibit2_res};

  genvar gi;
  generate
    for (gi = 0; gi < `N_INPUTS; gi = gi + 1) begin : g_in
      level_sampler u_samp (
        .aclk(aclk),
        .aresetn(aresetn),
        .res_code(res_bus[gi*`RES_W +: `RES_W]),
        .level_q(level_bus[gi*`PCT_W +: `PCT_W])
      );
      // thresholds taken straight from the per-input word [RULE7]
      band_sorter u_sort (
        .aclk(aclk),
        .aresetn(aresetn),
        .level(level_bus[gi*`PCT_W +: `PCT_W]),
        .thr_low(thr_q[gi][`F_THR_LOW +: `PCT_W]),
        .thr_mid(thr_q[gi][`F_THR_MID +: `PCT_W]),
        .thr_up(thr_q[gi][`F_THR_UP +: `PCT_W]),
        .band_q(band_bus[gi*`BAND_W +: `BAND_W]) // [RULE2] [RULE6]
      );
    end
  endgenerate

  // ==========================================================
  // helpers
  // band of an assigned input; valid=0 when off or out of range
  function [`BAND_W:0] band_of;
    input [`ASSIGN_W-1:0] asg;
    input [`BAND_W*`N_INPUTS-1:0] bands;
    reg [`ASSIGN_W-1:0] slot;
    begin
      slot = asg - `ASSIGN_FIRST;
      if (asg >= `ASSIGN_FIRST && asg <= `ASSIGN_LAST)
        band_of = {1'b1, bands[slot[1:0]*`BAND_W +: `BAND_W]};
      else
        band_of = {1'b0, `BAND_0};
    end
  endfunction

  // clamp a percentage field to 100
  function [`PCT_W-1:0] pct_clamp;
    input [7:0] v;
    begin
      if (v > {1'b0, `PCT_MAX})
        pct_clamp = `PCT_MAX;
      else
        pct_clamp = v[`PCT_W-1:0];
    end
  endfunction

  // byte-lane merge; percentage bytes clamp and keep bit 7 clear
  function [31:0] merge_pct;
    input [31:0] old;
    input [31:0] data;
    input [3:0] strb;
    integer b;
    begin
      merge_pct = old;
      for (b = 0; b < 4; b = b + 1) begin
        if (strb[b])
          merge_pct[b*8 +: 8] = {1'b0, pct_clamp(data[b*8 +: 8])}; // [RULE8]
      end
    end
  endfunction

  // plain byte-lane merge
  function [31:0] merge_raw;
    input [31:0] old;
    input [31:0] data;
    input [3:0] strb;
    integer b;
    begin
      merge_raw = old;
      for (b = 0; b < 4; b = b + 1) begin
        if (strb[b])
          merge_raw[b*8 +: 8] = data[b*8 +: 8];
      end
    end
  endfunction

  // ==========================================================
  // drive limit: lowest limit among active drive inhibits
  reg [`PCT_W-1:0] lim_d; // combined limit
  reg [`BAND_W:0] dsel; // valid + band of one drive inhibit
  reg [`PCT_W-1:0] cand; // that inhibit's limit
  integer di;

  always @* begin
    lim_d = `PCT_MAX; // no active inhibit leaves full speed
    dsel = {1'b0, `BAND_0};
    cand = `PCT_MAX;
    for (di = 0; di < `N_DRIVE; di = di + 1) begin
      dsel = band_of(dasg_q[di][`ASSIGN_W-1:0], band_bus); // [RULE10]
      cand = dspd_q[di][dsel[`BAND_W-1:0]*8 +: `PCT_W]; // [RULE11]
      if (dsel[`BAND_W] && cand < lim_d)
        lim_d = cand; // [RULE17]
    end
  end

  // ==========================================================
  // actuator blocking per channel and direction
  reg [`N_ACT-1:0] up_d; // up direction blocked
  reg [`N_ACT-1:0] dn_d; // down direction blocked
  reg [`BAND_W:0] usel; // up input band
  reg [`BAND_W:0] nsel; // down input band
  integer ai;

  always @* begin
    up_d = {`N_ACT{1'b0}};
    dn_d = {`N_ACT{1'b0}};
    usel = {1'b0, `BAND_0};
    nsel = {1'b0, `BAND_0};
    for (ai = 0; ai < `N_ACT; ai = ai + 1) begin
      // each direction looks up its own input, which may be the same one [RULE13] [RULE14]
      usel = band_of(act_q[ai][`F_ACT_UP_ASG +: `ASSIGN_W], band_bus);
      nsel = band_of(act_q[ai][`F_ACT_DN_ASG +: `ASSIGN_W], band_bus);
      up_d[ai] = usel[`BAND_W] & act_q[ai][`F_ACT_UP_FLG + usel[`BAND_W-1:0]]; // [RULE15]
      dn_d[ai] = nsel[`BAND_W] & act_q[ai][`F_ACT_DN_FLG + nsel[`BAND_W-1:0]]; // [RULE15]
    end
  end

  // ==========================================================
  // registered gating outputs
  always @(posedge aclk) begin
    if (!aresetn) begin
      drive_speed_limit_q <= `PCT_ZERO;
      drive_inhibit_q <= 1'b1; // brakes held until the first evaluation
      act_up_block_q <= {`N_ACT{1'b0}};
      act_down_block_q <= {`N_ACT{1'b0}};
    end else begin
      drive_speed_limit_q <= lim_d;
      drive_inhibit_q <= (lim_d == `PCT_ZERO); // [RULE12]
      act_up_block_q <= up_d;
      act_down_block_q <= dn_d;
    end
  end

  // ==========================================================
  // axi write channel: address and data taken in either order
  reg aw_have_q; // write address held
  reg w_have_q; // write data held
  reg [`IDX_W-1:0] aw_idx_q; // held word index
  reg [31:0] w_data_q; // held data
  reg [3:0] w_strb_q; // held strobes

  assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
  assign s_axi_wready = !w_have_q && !s_axi_bvalid;

  wire wr_go; // both halves present, perform write
  assign wr_go = aw_have_q && w_have_q && !s_axi_bvalid;

  // decode of the held write address
  wire wr_thr; // threshold word
  wire wr_dasg; // drive assignment word
  wire wr_dspd; // drive speed word
  wire wr_act; // actuator word
  wire [`IDX_W-1:0] wr_off_thr;
  wire [`IDX_W-1:0] wr_off_dasg;
  wire [`IDX_W-1:0] wr_off_dspd;
  wire [`IDX_W-1:0] wr_off_act;

  assign wr_off_thr = aw_idx_q - `IDX_THR_BASE;
  assign wr_off_dasg = aw_idx_q - `IDX_DASG_BASE;
  assign wr_off_dspd = aw_idx_q - `IDX_DSPD_BASE;
  assign wr_off_act = aw_idx_q - `IDX_ACT_BASE;
  assign wr_thr = aw_idx_q >= `IDX_THR_BASE && wr_off_thr < `N_INPUTS;
  assign wr_dasg = aw_idx_q >= `IDX_DASG_BASE && wr_off_dasg < `N_DRIVE;
  assign wr_dspd = aw_idx_q >= `IDX_DSPD_BASE && wr_off_dspd < `N_DRIVE;
  assign wr_act = aw_idx_q >= `IDX_ACT_BASE && wr_off_act < `N_ACT;

  integer ri;

  // handshake capture, register update and write response
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_idx_q <= {`IDX_W{1'b0}};
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      for (ri = 0; ri < `N_INPUTS; ri = ri + 1)
        thr_q[ri] <= `RST_THR;
      for (ri = 0; ri < `N_DRIVE; ri = ri + 1) begin
        dasg_q[ri] <= `RST_DASG;
        dspd_q[ri] <= `RST_DSPD;
      end
      for (ri = 0; ri < `N_ACT; ri = ri + 1)
        act_q[ri] <= `RST_ACT;
    end else begin
      // address half
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_idx_q <= s_axi_awaddr[7:2];
      end
      // data half
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      // both present: write and answer next cycle
      if (wr_go) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `RESP_OKAY;
        if (wr_thr)
          thr_q[wr_off_thr[1:0]] <= merge_pct(thr_q[wr_off_thr[1:0]], w_data_q, w_strb_q);
        else if (wr_dasg)
          dasg_q[wr_off_dasg[2:0]] <= merge_raw(dasg_q[wr_off_dasg[2:0]], w_data_q, w_strb_q);
        else if (wr_dspd)
          dspd_q[wr_off_dspd[2:0]] <= merge_pct(dspd_q[wr_off_dspd[2:0]], w_data_q, w_strb_q);
        else if (wr_act)
          act_q[wr_off_act[1:0]] <= merge_raw(act_q[wr_off_act[1:0]], w_data_q, w_strb_q);
        else
          s_axi_bresp <= `RESP_SLVERR; // unmapped or read-only word
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // axi read channel: one read at a time, data one cycle after address
  assign s_axi_arready = !s_axi_rvalid;

  wire [`IDX_W-1:0] rd_idx; // requested word index
  wire [`IDX_W-1:0] rd_off_thr;
  wire [`IDX_W-1:0] rd_off_dasg;
  wire [`IDX_W-1:0] rd_off_dspd;
  wire [`IDX_W-1:0] rd_off_act;

  assign rd_idx = s_axi_araddr[7:2];
  assign rd_off_thr = rd_idx - `IDX_THR_BASE;
  assign rd_off_dasg = rd_idx - `IDX_DASG_BASE;
  assign rd_off_dspd = rd_idx - `IDX_DSPD_BASE;
  assign rd_off_act = rd_idx - `IDX_ACT_BASE;

  // read mux, status words show live level, band, drive and block state
  reg [31:0] rd_data_d; // selected word
  reg rd_err_d; // unmapped

  always @* begin
    rd_data_d = 32'h00000000;
    rd_err_d = 1'b0;
    if (rd_idx >= `IDX_THR_BASE && rd_off_thr < `N_INPUTS)
      rd_data_d = thr_q[rd_off_thr[1:0]];
    else if (rd_idx >= `IDX_DASG_BASE && rd_off_dasg < `N_DRIVE)
      rd_data_d = dasg_q[rd_off_dasg[2:0]];
    else if (rd_idx >= `IDX_DSPD_BASE && rd_off_dspd < `N_DRIVE)
      rd_data_d = dspd_q[rd_off_dspd[2:0]];
    else if (rd_idx >= `IDX_ACT_BASE && rd_off_act < `N_ACT)
      rd_data_d = act_q[rd_off_act[1:0]];
    else if (rd_idx == `IDX_LEVEL)
      rd_data_d = {1'b0, level_bus[27:21], 1'b0, level_bus[20:14],
                   1'b0, level_bus[13:7], 1'b0, level_bus[6:0]};
    else if (rd_idx == `IDX_BAND)
      rd_data_d = {24'h000000, band_bus};
    else if (rd_idx == `IDX_DRIVE)
      rd_data_d = {23'h000000, drive_inhibit_q, 1'b0, drive_speed_limit_q};
    else if (rd_idx == `IDX_BLOCK)
      rd_data_d = {20'h00000, act_down_block_q, 4'h0, act_up_block_q};
    else
      rd_err_d = 1'b1; // unmapped reads zero with an error
  end

  // read answer register
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_data_d;
      s_axi_rresp <= rd_err_d ? `RESP_SLVERR : `RESP_OKAY;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // inhibit_band_classifier

// file: dv/inhibit_network.sv
// switch and resistor network model on the four inhibit inputs
`timescale 1ns/1ps
`include "inhibit_regs.vh"

module inhibit_network (
  input wire [31:0] res_set, // resistance per input, 100 ohm units, input 2 low byte
  input wire [3:0] open_set, // switch open, no path to ground
  output wire [`RES_W-1:0] res2,
  output wire [`RES_W-1:0] res3,
  output wire [`RES_W-1:0] res4,
  output wire [`RES_W-1:0] res5
);
  // ==========================================================
  // open circuit reads far past the saturation point, not as a held value
  assign res2 = open_set[0] ? 8'hff : res_set[7:0];
  assign res3 = open_set[1] ? 8'hff : res_set[15:8];
  assign res4 = open_set[2] ? 8'hff : res_set[23:16];
  assign res5 = open_set[3] ? 8'hff : res_set[31:24];
endmodule // inhibit_network

// file: dv/classifier_sva.sv
// port checker for the inhibit band classifier
`timescale 1ns/1ps
`include "inhibit_regs.vh"

module classifier_sva (
  input wire aclk,
  input wire aresetn,
  input wire [`RES_W-1:0] pm_inhibit2_res,
  input wire [`RES_W-1:0] pm_inhibit3_res,
  input wire [`RES_W-1:0] seating_lighting_unit_inhibit4_res,
  input wire [`RES_W-1:0] seating_lighting_unit_inhibit5_res,
  input wire [`PCT_W-1:0] drive_speed_limit_q,
  input wire drive_inhibit_q,
  input wire [`N_ACT-1:0] act_up_block_q,
  input wire [`N_ACT-1:0] act_down_block_q,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready
);
  // ==========================================================
  // quiet counter: a change or a write restarts it
  wire [31:0] res_all = {pm_inhibit2_res, pm_inhibit3_res,
    seating_lighting_unit_inhibit4_res, seating_lighting_unit_inhibit5_res};
  wire wr_seen = (s_axi_awvalid & s_axi_awready) | (s_axi_wvalid & s_axi_wready);
  logic [31:0] res_last_q; // inputs one edge ago
  logic [3:0] quiet_q; // saturates, sync plus two stages fit well inside 10
  always @(posedge aclk) begin
    res_last_q <= res_all;
    if (!aresetn || wr_seen || res_all != res_last_q) begin
      quiet_q <= 4'h0;
    end else if (quiet_q != 4'hf) begin
      quiet_q <= quiet_q + 4'h1;
    end
  end

  // ==========================================================
  // properties
  chk_quiet_stable: assert property (@(posedge aclk) disable iff (!aresetn)
    quiet_q > 4'h9 |-> $stable({drive_speed_limit_q, drive_inhibit_q, act_up_block_q,
    act_down_block_q})) else $error("outputs moved with quiet inputs");
  chk_limit_range: assert property (@(posedge aclk) disable iff (!aresetn)
    drive_speed_limit_q <= `PCT_MAX) else $error("limit above full scale");
  chk_full_inhibit: assert property (@(posedge aclk) disable iff (!aresetn)
    drive_inhibit_q == (drive_speed_limit_q == `PCT_ZERO)) else $error("inhibit vs zero limit");
  chk_bresp_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  chk_rdata_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  chk_write_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid)
    else $error("write answer late");
  chk_read_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
  chk_unmapped_read: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h8f |=>
    s_axi_rresp == `RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read answer");
endmodule // classifier_sva

bind inhibit_band_classifier classifier_sva classifier_sva_inst (.aclk(aclk),
  .aresetn(aresetn), .pm_inhibit2_res(pm_inhibit2_res), .pm_inhibit3_res(pm_inhibit3_res),
  .seating_lighting_unit_inhibit4_res(seating_lighting_unit_inhibit4_res),
  .seating_lighting_unit_inhibit5_res(seating_lighting_unit_inhibit5_res),
  .drive_speed_limit_q(drive_speed_limit_q), .drive_inhibit_q(drive_inhibit_q),
  .act_up_block_q(act_up_block_q), .act_down_block_q(act_down_block_q),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// file: dv/inhibit_band_classifier_tb.sv
// self-checking bench for the inhibit band classifier
`timescale 1ns/1ps
`include "inhibit_regs.vh"

module inhibit_band_classifier_tb;
  // ==========================================================
  // stimulus and observed signals
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] res_set = 32'h0; // network setting, input 2 low byte
  logic [3:0] open_set = 4'h0;
  logic [7:0] awaddr = 8'h0;
  logic [7:0] araddr = 8'h0;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic slow_rdy = 1'b0; // hold off bready/rready so the answer must stand
  wire [`RES_W-1:0] res2, res3, res4, res5;
  wire [`PCT_W-1:0] lim;
  wire inh, awready, wready, bvalid, arready, rvalid;
  wire [`N_ACT-1:0] up_blk, dn_blk;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  int fails = 0;
  int cmp_count = 0;

  always #20 aclk = ~aclk; // 25 mhz

  inhibit_network inhibit_network_inst (.res_set(res_set), .open_set(open_set),
    .res2(res2), .res3(res3), .res4(res4), .res5(res5));
  inhibit_band_classifier inhibit_band_classifier_inst (.aclk(aclk), .aresetn(aresetn),
    .pm_inhibit2_res(res2), .pm_inhibit3_res(res3),
    .seating_lighting_unit_inhibit4_res(res4), .seating_lighting_unit_inhibit5_res(res5),
    .drive_speed_limit_q(lim), .drive_inhibit_q(inh),
    .act_up_block_q(up_blk), .act_down_block_q(dn_blk),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  // ==========================================================
  // shared helpers
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic test_done;
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // both halves offered together; without slow_rdy, bready stays up until the answer
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= !slow_rdy;
    n = 0;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      n++;
    end while (n < 50 && (awvalid || wvalid));
    // late bready: the answer has to wait, then one handshake edge
    if (slow_rdy) begin
      repeat (3) @(posedge aclk);
      bready <= 1'b1;
      @(posedge aclk);
    end
    for (n = 0; n < 50 && bvalid !== 1'b1; n++) @(posedge aclk);
    chk("bvalid", {31'h0, bvalid}, 32'h1);
    chk("bresp", {30'h0, bresp}, {30'h0, er});
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= !slow_rdy;
    n = 0;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      n++;
    end while (n < 50 && arvalid);
    // late rready: read data must stand until taken
    if (slow_rdy) begin
      repeat (3) @(posedge aclk);
      rready <= 1'b1;
      @(posedge aclk);
    end
    for (n = 0; n < 50 && rvalid !== 1'b1; n++) @(posedge aclk);
    chk("rvalid", {31'h0, rvalid}, 32'h1);
    chk($sformatf("rdata %h", a), rdata, exp);
    chk("rresp", {30'h0, rresp}, {30'h0, er});
    rready <= 1'b0;
  endtask

  // sync, band and output stages all land well inside this
  task automatic settle;
    repeat (12) @(posedge aclk);
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset;
    rd(8'h10, `RST_THR, `RESP_OKAY);
    rd(8'h40, `RST_DSPD, `RESP_OKAY);
    chk("limit", lim, `PCT_MAX);
    chk("up block", up_blk, 4'h0);
    slow_rdy = 1'b1;
    wr(8'h88, 32'h0, `RESP_SLVERR);
    rd(8'h90, 32'h0, `RESP_SLVERR);
    slow_rdy = 1'b0;
  endtask

  task automatic t_levels;
    @(posedge aclk);
    res_set <= 32'hc8642f00;
    settle;
    rd(8'h80, 32'h64642f00, `RESP_OKAY);
  endtask

  task automatic t_bands;
    logic [7:0] cd [6] = '{8'h0b, 8'h0c, 8'h21, 8'h22, 8'h35, 8'h36};
    logic [1:0] bd [6] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3};
    wr(8'h10, 32'h0036220c, `RESP_OKAY);
    wr(8'h1c, 32'h007f7f7f, `RESP_OKAY);
    rd(8'h1c, 32'h00646464, `RESP_OKAY);
    for (int i = 0; i < 6; i++) begin
      @(posedge aclk);
      res_set[7:0] <= cd[i];
      settle;
      rd(8'h84, {24'h0, 6'h3f, bd[i]}, `RESP_OKAY);
    end
  endtask

  task automatic t_drive;
    logic [7:0] cd [4] = '{8'h00, 8'h16, 8'h2c, 8'h00};
    logic [6:0] lm [4] = '{7'h64, 7'h32, 7'h19, 7'h00};
    wr(8'h20, 32'h2, `RESP_OKAY);
    wr(8'h40, 32'h00193264, `RESP_OKAY);
    for (int i = 0; i < 4; i++) begin
      @(posedge aclk);
      res_set[7:0] <= cd[i];
      open_set[0] <= (i == 3);
      settle;
      chk("limit", lim, lm[i]);
      chk("inhibit", inh, i == 3);
    end
    @(posedge aclk);
    open_set <= 4'h0;
    wr(8'h24, 32'h3, `RESP_OKAY);
    wr(8'h44, 32'h1e1e1e1e, `RESP_OKAY);
    settle;
    rd(8'h88, 32'h0000001e, `RESP_OKAY);
  endtask

  task automatic t_act;
    logic [7:0] lv [3] = '{8'h00, 8'h3c, 8'h64};
    logic [3:0] ue [3] = '{4'h8, 4'h0, 4'h0};
    logic [3:0] de [3] = '{4'h0, 4'h0, 4'h8};
    wr(8'h18, 32'h00503214, `RESP_OKAY);
    wr(8'h6c, 32'h00008414, `RESP_OKAY);
    for (int i = 0; i < 3; i++) begin
      @(posedge aclk);
      res_set[23:16] <= lv[i];
      settle;
      chk("up block", up_blk, ue[i]);
      chk("down block", dn_blk, de[i]);
    end
  endtask

  // ==========================================================
  // main sequence and watchdog
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    settle;
    t_reset;
    t_levels;
    t_bands;
    t_drive;
    t_act;
    test_done;
  end

  initial begin
    repeat (20000) @(posedge aclk);
    fails++;
    test_done;
  end
endmodule // inhibit_band_classifier_tb
